// File: inc/wwdt_defs.svh
// Constants for the windowed watchdog: register map, reset values, timing.
// Assumes inclusion by bare name from design files that need the figures.
`ifndef WWDT_DEFS_SVH
`define WWDT_DEFS_SVH

`define WWDT_ADDR_W        16
`define WWDT_CTRL_ADDR     16'h002A
`define WWDT_CTRL_RESET    8'h7F
`define WWDT_ACT_BIT       7
`define WWDT_TOP_BIT       6
`define WWDT_CNT_RESET     7'h7F
`define WWDT_PRESCALE      14'h3FFF
`define WWDT_PRE_W         14
`define WWDT_OSC_DIV       8'h01
`define WWDT_DLY_SHORT     13'h00FF
`define WWDT_DLY_LONG      13'h0FFF
`define WWDT_DLY_W         13
`define WWDT_RST_NS        500
`define WWDT_CLK_NS        10
`define WWDT_RST_CYC       ((`WWDT_RST_NS + `WWDT_CLK_NS - 1) / `WWDT_CLK_NS)
`define WWDT_RST_W         7

`endif

// File: inc/wwdt_pkg.sv
// Types shared by the watchdog design files.
// Assumes the defs header is included where constants are needed.
package wwdt_pkg;

   typedef enum logic [1:0] {
      WWDT_RUN,
      WWDT_HALT_ONCE,
      WWDT_FROZEN,
      WWDT_RESUME
   } wwdt_state_type;

   typedef struct packed {
      logic halt_enter;
      logic wake_ext;
      logic wake_osc;
   } wwdt_core_type;

   typedef struct packed {
      logic       hw_watchdog;
      logic       halt_reset_option;
      logic       timebase_irq_enable;
      logic [1:0] timebase_select;
      logic       long_wake_delay;
   } wwdt_cfg_type;

endpackage

// File: logic/wwdt_pulse.sv
// Stretcher that holds the reset pin low for a fixed number of cycles.
// Assumes a one-cycle trigger pulse on clk_sys.
`timescale 1ns/1ns
`default_nettype none
`include "wwdt_defs.svh"

module wwdt_pulse (
   input  wire logic clk_sys,
   input  wire logic resetn,
   input  wire logic trigger,
   output logic      reset_pin_n
);

   logic [`WWDT_RST_W-1:0] count;
   wire                    busy = (count != '0);

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         count <= '0;
      end else if (trigger) begin
         count <= `WWDT_RST_W'(`WWDT_RST_CYC);
      end else if (busy) begin
         count <= count - `WWDT_RST_W'(1);
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         reset_pin_n <= 1'b1;
      end else begin
         reset_pin_n <= !(trigger || (count > `WWDT_RST_W'(1)));
      end
   end

endmodule
`default_nettype wire

// File: logic/wwdt_core.sv
// Windowed watchdog top: control register, prescaler, countdown, halt handling.
// Assumes a plain register port from the core and core halt/wake indications.
//
// Summary of operation
// RL1: Software must write the counter top bit as one on every write.
// RL2: Countdown decrements once every 16384 divided oscillator periods.
// RL3: Active watchdog resets when the count passes from 40h to 3Fh.
// RL4: Activation bit set only by write; cleared only by system reset.
// RL5: Watchdog may reset only with activation bit set; halt_reset fires without it.
// RL6: Hardware-watchdog option makes watchdog always active.
// RL7: Control register reads 7Fh after reset.
// RL8: Low six counter bits give the number of steps before reset.
// RL9: Timeout bounds depend on per-timebase constants from timebase selection; the timeout here does not change with timebase_select.
// RL10: First decrement after write falls inside prescaler phase window.
// RL11: Plain halt without options: decrement once, then stop without reset.
// RL12: External wake from stopped halt resumes after 256 or 4096 clocks.
// RL13: Reset ending halt leaves watchdog disabled unless hardware option set.
// RL14: Halt with halt-reset option and no timebase enable resets at once.
// RL15: Halt with timebase enable freezes counter; interrupt resumes at once.
// RL16: Reset ending active-halt resumes counting after 256 or 4096 clocks.
// RL17: Control register at 002Ah: activation bit 7, counter bits 6:0.
// RL18: Software should reload the counter just before entering halt.
// RL19: Countdown runs even while the watchdog is not activated.
// RL20: Watchdog reset drives reset pin low for about 500 ns.
// RL21: Writing activation set with top bit clear forces a reset.
// RL22: Halt, wake and option bits arrive as plain inputs.
`timescale 1ns/1ns
`default_nettype none
`include "wwdt_defs.svh"

module wwdt_core (
   input  wire logic                     clk_sys,
   input  wire logic                     resetn,
   input  wire logic [`WWDT_ADDR_W-1:0]  reg_addr,
   input  wire logic [7:0]               reg_wdata,
   input  wire logic                     reg_write,
   input  wire logic                     reg_read,
   output logic      [7:0]               reg_rdata,
   input  wire wwdt_pkg::wwdt_core_type  core_event,
   input  wire wwdt_pkg::wwdt_cfg_type   config_in,
   input  wire logic                     resumed_from_halt,
   output logic                          reset_pin_n,
   output logic                          watchdog_reset
);

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic                      activation_bit;
   logic [6:0]                load_count;
   logic [`WWDT_PRE_W-1:0]    prescaler;
   logic [`WWDT_DLY_W-1:0]    resume_delay;
   logic                      boot_delay;
   wwdt_pkg::wwdt_state_type  state;
   wwdt_pkg::wwdt_state_type  next_state;
   logic                      fire;

   // ----------------------------------------------------------------
   // Decoding
   // ----------------------------------------------------------------
   // Halt inputs are sourced from the core on clk_sys, so no synchroniser
   wire ctrl_hit     = (reg_addr == `WWDT_CTRL_ADDR);                    // [RL17]
   wire ctrl_write   = reg_write && ctrl_hit;
   wire active       = activation_bit || config_in.hw_watchdog;         // [RL5] [RL6]
   wire counting     = (state == wwdt_pkg::WWDT_RUN) ||
                       (state == wwdt_pkg::WWDT_HALT_ONCE);
   wire tick         = counting && (prescaler == `WWDT_PRESCALE);       // [RL2]
   wire counter_top_bit = load_count[`WWDT_TOP_BIT];
   wire [6:0] dec_count = load_count - 7'h01;
   wire roll_over    = tick && counter_top_bit && !dec_count[`WWDT_TOP_BIT];  // [RL3]
   wire sw_force     = ctrl_write && (reg_wdata[`WWDT_ACT_BIT] || active)
                       && !reg_wdata[`WWDT_TOP_BIT];                    // [RL21] [RL1]
   wire plain_halt   = core_event.halt_enter && !config_in.timebase_irq_enable;  // [RL22]
   wire halt_reset   = plain_halt && config_in.halt_reset_option;       // [RL14]
   wire wake_any     = core_event.wake_ext || core_event.wake_osc;
   wire [`WWDT_DLY_W-1:0] wake_delay = config_in.long_wake_delay ?
                                       `WWDT_DLY_LONG : `WWDT_DLY_SHORT;
   // Timebase constants reach only read_value, which the read port masks to zero
   wire [5:0] tb_low_const = (config_in.timebase_select == 2'b00) ? 6'h3B :
                             (config_in.timebase_select == 2'b01) ? 6'h35 :
                             (config_in.timebase_select == 2'b10) ? 6'h23 : 6'h36;  // [RL9]

   // ----------------------------------------------------------------
   // Prescaler and counter
   // ----------------------------------------------------------------
   // Prescaler is not cleared on write, so the first step lands anywhere in a period
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         prescaler <= '0;
      end else if (counting) begin
         prescaler <= prescaler + `WWDT_PRE_W'(1);                      // [RL10] [RL19]
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         load_count <= `WWDT_CNT_RESET;                                 // [RL7]
      end else if (ctrl_write) begin
         load_count <= reg_wdata[6:0];                                  // [RL8]
      end else if (tick) begin
         load_count <= dec_count;                                       // [RL19]
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         activation_bit <= 1'b0;                                        // [RL7] [RL13]
      end else if (ctrl_write && reg_wdata[`WWDT_ACT_BIT]) begin
         activation_bit <= 1'b1;                                        // [RL4]
      end
   end

   // ----------------------------------------------------------------
   // Halt sequencing
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         wwdt_pkg::WWDT_RUN: begin
            if (core_event.halt_enter && config_in.timebase_irq_enable) begin
               next_state = wwdt_pkg::WWDT_FROZEN;                      // [RL15]
            end else if (plain_halt && !config_in.halt_reset_option) begin
               next_state = wwdt_pkg::WWDT_HALT_ONCE;                   // [RL11]
            end
         end
         wwdt_pkg::WWDT_HALT_ONCE: begin
            if (core_event.wake_ext) begin
               next_state = wwdt_pkg::WWDT_RESUME;                      // [RL12]
            end else if (tick) begin
               next_state = wwdt_pkg::WWDT_FROZEN;                      // [RL11]
            end
         end
         wwdt_pkg::WWDT_FROZEN: begin
            if (wake_any) begin
               next_state = config_in.timebase_irq_enable ?
                            wwdt_pkg::WWDT_RUN : wwdt_pkg::WWDT_RESUME; // [RL15] [RL12]
            end
         end
         wwdt_pkg::WWDT_RESUME: begin
            if (resume_delay == '0) begin
               next_state = wwdt_pkg::WWDT_RUN;
            end
         end
         default: begin
            next_state = wwdt_pkg::WWDT_RUN;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state <= wwdt_pkg::WWDT_RESUME;
      end else if (boot_delay) begin
         state <= config_in.timebase_irq_enable || !resumed_from_halt ?
                  wwdt_pkg::WWDT_RESUME : wwdt_pkg::WWDT_RUN;           // [RL16]
      end else begin
         state <= next_state;
      end
   end

   // Reset release samples the wake-up option once, after the edge
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         boot_delay <= 1'b1;
      end else begin
         boot_delay <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         resume_delay <= '0;
      end else if (boot_delay || (next_state == wwdt_pkg::WWDT_RESUME &&
                                  state != wwdt_pkg::WWDT_RESUME)) begin
         resume_delay <= (boot_delay && !resumed_from_halt) ? '0 : wake_delay;  // [RL16] [RL12]
      end else if (resume_delay != '0) begin
         resume_delay <= resume_delay - `WWDT_DLY_W'(1);
      end
   end

   // ----------------------------------------------------------------
   // Reset generation and read port
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         fire <= 1'b0;
      end else begin
         fire <= (active && roll_over && (state == wwdt_pkg::WWDT_RUN)) // [RL3] [RL5]
                 || sw_force || halt_reset;                             // [RL21] [RL14]
      end
   end

   assign watchdog_reset = fire;

   wwdt_pulse u_pulse (
      .clk_sys     (clk_sys),
      .resetn      (resetn),
      .trigger     (fire),
      .reset_pin_n (reset_pin_n)                                       // [RL20]
   );

   wire [7:0] read_value = ctrl_hit ? {activation_bit, load_count} : {2'b00, tb_low_const};

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
      end else if (reg_read) begin
         reg_rdata <= ctrl_hit ? read_value : 8'h00;                    // [RL17]
      end
   end

endmodule
`default_nettype wire

// File: sim/wwdt_core_sva.sv
// Concurrent checks on the watchdog top module ports.
// Assumes binding onto wwdt_core; sees only its ports.
`timescale 1ns/1ns
`default_nettype none
`include "wwdt_defs.svh"
module wwdt_core_sva (
   input wire logic                    clk_sys,
   input wire logic                    resetn,
   input wire logic [`WWDT_ADDR_W-1:0] reg_addr,
   input wire logic [7:0]              reg_wdata,
   input wire logic                    reg_write,
   input wire logic                    reg_read,
   input wire logic [7:0]              reg_rdata,
   input wire wwdt_pkg::wwdt_core_type core_event,
   input wire wwdt_pkg::wwdt_cfg_type  config_in,
   input wire logic                    resumed_from_halt,
   input wire logic                    reset_pin_n,
   input wire logic                    watchdog_reset
);
   // ------------------------------------------
   // Helpers: pin low time, activation written
   // ------------------------------------------
   wire        ctrl_hit = (reg_addr == `WWDT_CTRL_ADDR);
   logic [6:0] low_cnt;
   logic       act_seen;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         low_cnt  <= 7'h00;
         act_seen <= 1'b0;
      end else begin
         low_cnt  <= reset_pin_n ? 7'h00 : low_cnt + 7'h01;
         act_seen <= act_seen | (reg_write & ctrl_hit & reg_wdata[7]);
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // ------------------------------------------
   // Assertions
   // ------------------------------------------
   pulse_once_a: assert property (watchdog_reset |=> !watchdog_reset)
      else $error("watchdog reset longer than one cycle");
   pin_follows_a: assert property (watchdog_reset |=> !reset_pin_n)
      else $error("reset pin not low after watchdog reset");
   pin_cause_a: assert property ($fell(reset_pin_n) |-> $past(watchdog_reset))
      else $error("reset pin fell without watchdog reset");
   pin_width_a: assert property ($rose(reset_pin_n) |-> low_cnt == 7'h32)
      else $error("reset pin low time wrong");
   forced_reset_a: assert property (reg_write && ctrl_hit && reg_wdata[7] && !reg_wdata[6]
      |-> ##[1:2] watchdog_reset) else $error("forced reset missing");
   halt_reset_a: assert property (core_event.halt_enter && config_in.halt_reset_option
      && !config_in.timebase_irq_enable |-> ##[1:2] watchdog_reset) else $error("halt reset missing");
   act_sticky_a: assert property (reg_read && ctrl_hit && !config_in.hw_watchdog
      |=> reg_rdata[7] == act_seen) else $error("activation bit wrong");
   unmapped_zero_a: assert property (reg_read && !ctrl_hit |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   rdata_hold_a: assert property (!reg_read |=> $stable(reg_rdata))
      else $error("read data changed without read");
   cover property (watchdog_reset);
   cover property (core_event.halt_enter && config_in.timebase_irq_enable);
   cover property ($rose(reset_pin_n));
endmodule
bind wwdt_core wwdt_core_sva chk (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .core_event(core_event), .config_in(config_in), .resumed_from_halt(resumed_from_halt),
   .reset_pin_n(reset_pin_n), .watchdog_reset(watchdog_reset));
`default_nettype wire

// File: sim/wwdt_core_test.sv
// Self-checking bench for the watchdog top.
// Assumes divided oscillator clock equals clk_sys; run stays under 95000 cycles.
`timescale 1ns/1ns
`default_nettype none
module wwdt_core_test;
   logic                    clk_sys, resetn, reg_write, reg_read, resumed_from_halt;
   logic                    reset_pin_n, watchdog_reset;
   logic [15:0]             reg_addr;
   logic [7:0]              reg_wdata, reg_rdata, rd, w;
   wwdt_pkg::wwdt_core_type core_event;
   wwdt_pkg::wwdt_cfg_type  config_in;
   int                      fail_count, n_checks, cyc, seed;
   localparam int PIN_LOW = 500 / 10;
   localparam int STEP    = 16384 + 16;
   wwdt_core dut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .core_event(core_event),
      .config_in(config_in), .resumed_from_halt(resumed_from_halt), .reset_pin_n(reset_pin_n),
      .watchdog_reset(watchdog_reset));
   // ------------------------------------------
   // Clock, timeout, report
   // ------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 95000) begin
         fail_count++;
         end_sim;
      end
   end
   task end_sim;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk_byte(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task chk_flag(input logic got, input logic exp);
      chk_byte({7'h00, got}, {7'h00, exp});
   endtask
   // Prescaler phase is unknown, so one step may already have landed
   function logic [7:0] near(input logic [7:0] got, input logic [7:0] exp);
      return (got[6:0] == exp[6:0] - 7'h01) ? {got[7], exp[6:0]} : got;
   endfunction
   // ------------------------------------------
   // Bus, event and reset tasks
   // ------------------------------------------
   task wr(input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr  <= 16'h002A;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk_sys);
      reg_write <= 1'b0;
   endtask
   task rdreg(input logic [15:0] a);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk_sys);
      reg_read <= 1'b0;
      @(negedge clk_sys);
      rd = reg_rdata;
   endtask
   task evt(input wwdt_pkg::wwdt_core_type e);
      @(posedge clk_sys);
      core_event <= e;
      @(posedge clk_sys);
      core_event <= '0;
   endtask
   task do_reset;
      @(posedge clk_sys);
      resetn <= 1'b0;
      repeat (12) @(posedge clk_sys);
      resetn <= 1'b1;
   endtask
   task wait_wd(input int n, input logic e);
      int   i;
      int   low;
      logic seen;
      seen = 1'b0;
      low  = 0;
      for (i = 0; i < n && !seen; i++) begin
         @(negedge clk_sys);
         seen = (watchdog_reset === 1'b1);
      end
      chk_flag(seen, e);
      // Pin is registered behind the pulse, so it falls one cycle later
      if (seen) @(negedge clk_sys);
      while (seen && reset_pin_n === 1'b0 && low < 60) begin
         low++;
         @(negedge clk_sys);
      end
      if (seen) chk_byte(8'(low), 8'(PIN_LOW));
   endtask
   // ------------------------------------------
   // Scenarios
   // ------------------------------------------
   initial begin
      seed = 58729;
      {resetn, reg_write, reg_read, resumed_from_halt} = 4'h0;
      reg_addr = 16'h0000;
      reg_wdata = 8'h00;
      core_event = '0;
      config_in = '0;
      repeat (12) @(posedge clk_sys);
      resetn <= 1'b1;
      rdreg(16'h002A);
      chk_byte(rd, 8'h7F);
      rdreg(16'h002B + 16'($random(seed) & 255));
      chk_byte(rd, 8'h00);
      for (int k = 0; k < 6; k++) begin
         w = 8'h40 | 8'($random(seed) & 63);
         wr(w);
         rdreg(16'h002A);
         chk_byte(near(rd, w), w);
      end
      wr(8'h3F);
      wait_wd(4, 1'b0);
      $display("map test done");
      wr(8'hFF);
      evt(3'b100);
      wait_wd(2 * 16384 + 32, 1'b0);
      rdreg(16'h002A);
      chk_byte(near(rd, 8'hFE), 8'hFE);
      @(posedge clk_sys);
      resumed_from_halt <= 1'b1;
      do_reset;
      rdreg(16'h002A);
      chk_byte(rd, 8'h7F);
      $display("halt test done");
      @(posedge clk_sys);
      resumed_from_halt <= 1'b0;
      config_in.timebase_irq_enable <= 1'b1;
      evt(3'b100);
      rdreg(16'h002A);
      w = rd;
      wait_wd(STEP, 1'b0);
      rdreg(16'h002A);
      chk_byte(rd, w);
      evt(3'b001);
      config_in.timebase_irq_enable <= 1'b0;
      $display("active halt test done");
      wr(8'hC5);
      wr(8'h45);
      rdreg(16'h002A);
      chk_flag(rd[7], 1'b1);
      wr(8'h40);
      wait_wd(STEP, 1'b1);
      do_reset;
      wr(8'hC0);
      wr(8'h80);
      wait_wd(4, 1'b1);
      do_reset;
      config_in.halt_reset_option <= 1'b1;
      evt(3'b100);
      wait_wd(4, 1'b1);
      @(posedge clk_sys);
      config_in.halt_reset_option <= 1'b0;
      config_in.hw_watchdog <= 1'b1;
      // Reset ending active-halt: counting waits the short resume delay first
      config_in.timebase_irq_enable <= 1'b1;
      resumed_from_halt <= 1'b1;
      do_reset;
      wr(8'h40);
      wait_wd(16384 + 100, 1'b0);
      wait_wd(400, 1'b1);
      $display("reset tests done");
      end_sim;
   end
endmodule
`default_nettype wire
